// File: tpio_chan.sv
// Purpose: One register and pin: decode code, drive pin, flag captures
// Assumes: Pin input already synchronised by the top module
// Notes: Shared by both channels; cross-trigger comes in as trig_evt
`timescale 1ns/1ps
`default_nettype none
module tpio_chan (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire tpio_pkg::tpio_code_t code,
  input wire logic code_wr,
  input wire logic inhibit,
  input wire logic standby,
  // Timer side
  input wire tpio_pkg::tpio_chan_in_t cin,
  output var tpio_pkg::tpio_chan_out_t cout
);
  import tpio_pkg::*;
  logic pin_reg;
  logic prev_reg;
  logic cap_reg;
  tpio_role_t role;
  logic rise;
  logic fall;
  logic edge_hit;
  logic wr_seen_reg;
  logic low_hold_reg;

  // role decode
  // Codes 0000 and 0100 fall to the hold role: no pin action, no event
  always_comb begin
    if (code[3])
      role = TPIO_CAP;
    else if (code[1:0] != 2'b00)
      role = TPIO_CMP;
    else
      role = TPIO_OFF;
  end

  assign rise = cin.pin_in & ~prev_reg;
  assign fall = ~cin.pin_in & prev_reg;

  always_comb begin
    if (code[2])
      edge_hit = cin.trig_evt;
    else if (code[1])
      edge_hit = rise | fall;
    else if (code[0])
      edge_hit = fall;
    else
      edge_hit = rise;
  end

  // Previous pin sample for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      prev_reg <= 1'b0;
    else
      prev_reg <= cin.pin_in;
  end

  // Write strobe delayed one edge; by then the field holds the new code,
  // so the initial level comes from the written value, not the old one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      wr_seen_reg <= 1'b0;
    else
      wr_seen_reg <= code_wr;
  end

  // low hold flag
  // Standby wins over a write in the same cycle, so it is never lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      low_hold_reg <= 1'b1;
    else if (standby)
      low_hold_reg <= 1'b1;
    else if (wr_seen_reg)
      low_hold_reg <= 1'b0;
  end

  // pin actions
  // Matches are ignored while the low hold stands
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_reg <= 1'b0;
    end else if (standby) begin
      pin_reg <= 1'b0;
    end else if (wr_seen_reg && !inhibit && !code[3]
                 && code[1:0] != 2'b00) begin
      pin_reg <= code[2];
    end else if (role == TPIO_CMP && !inhibit && !low_hold_reg
                 && cin.cmp_match) begin
      case (code[1:0])
        2'b01: pin_reg <= 1'b0;
        2'b10: pin_reg <= 1'b1;
        2'b11: pin_reg <= ~pin_reg;
        default: pin_reg <= pin_reg;
      endcase
    end
  end

  // One-cycle capture strobe, registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      cap_reg <= 1'b0;
    else
      cap_reg <= (role == TPIO_CAP) && !inhibit && !standby && edge_hit;
  end

  assign cout.pin_out = pin_reg;
  assign cout.pin_oe = (role != TPIO_CAP);
  assign cout.cap_strobe = cap_reg;
  assign cout.cmp_en = (role == TPIO_CMP) && !inhibit;
endmodule
`default_nettype wire

// File: tpio_defines.svh
// Purpose: Offsets, field positions and reset values for the pin I/O block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Included by the top module file only
`ifndef TPIO_DEFINES_SVH
`define TPIO_DEFINES_SVH
`define TPIO_OFS_CH0_LOW_IO 12'h000
`define TPIO_OFS_CH1_IO 12'h004
`define TPIO_OFS_CH0_MODE 12'h008
`define TPIO_OFS_STATUS 12'h00C
`define TPIO_IO_RESET 8'h00
`define TPIO_FLD_LO 0
`define TPIO_FLD_HI 3
`define TPIO_BUF_BIT 0
`endif

// File: tpio_pkg.sv
// Purpose: Types shared by the pin I/O mode select block
// Assumes: Fields are four bits wide
// Notes: Constants live in the defines header
package tpio_pkg;
  typedef logic [3:0] tpio_code_t;
  typedef enum logic [1:0] {
    TPIO_OFF = 2'b00,
    TPIO_CMP = 2'b01,
    TPIO_CAP = 2'b10
  } tpio_role_t;
  typedef struct packed {
    logic cmp_match;
    logic pin_in;
    logic trig_evt;
  } tpio_chan_in_t;
  typedef struct packed {
    logic pin_out;
    logic pin_oe;
    logic cap_strobe;
    logic cmp_en;
  } tpio_chan_out_t;
endpackage

// File: tpio_timer_model.sv
// Purpose: Timer side stand-in driving events and pin levels
// Assumes: Events are one-cycle pulses on the block clock
// Notes: A pin follows the block while its enable is high
`timescale 1ns/1ps
`default_nettype none
module tpio_timer_model (
  // Clock
  input wire logic clk,
  // Block pin drive
  input wire logic o0,
  input wire logic oe0,
  input wire logic o1,
  input wire logic oe1,
  // Pin levels seen by the block
  output logic pin0,
  output logic pin1,
  // Timer events
  output logic match0,
  output logic match1,
  output logic step,
  output logic event0
);
  logic drv0;
  logic drv1;
  // Quiet at time zero
  initial begin
    {event0, step, match1, match0} = 4'h0;
    drv0 = 1'b0;
    drv1 = 1'b0;
  end
  // Block wins while it drives, else the outside source
  assign pin0 = oe0 ? o0 : drv0;
  assign pin1 = oe1 ? o1 : drv1;
  // One-cycle pulse; callers never start two in one time step
  task automatic pulse(input logic [3:0] k);
    {event0, step, match1, match0} <= k;
    @(posedge clk);
    {event0, step, match1, match0} <= 4'h0;
  endtask
  // Outside pin source, both pins together
  task automatic set_pins(input logic v);
    drv0 <= v;
    drv1 <= v;
  endtask
endmodule
`default_nettype wire

// File: tpio_top.sv
// Purpose: APB slave holding pin I/O control fields for two timer registers
// Assumes: APB3 slave, zero wait states, MCLK 200 MHz
// Notes: Counters and compare logic sit outside this block
//
// Function
// - Compare code with low bits 01 starts the pin at bit 2, drives low.
// - Compare code with low bits 10 starts the pin at bit 2, drives high.
// - Compare code with low bits 11 starts the pin at bit 2, toggles.
// - Code 10x00 captures the counter on a rising pin edge.
// - Code 10x01 captures the counter on a falling pin edge.
// - Code 10 with bit 1 set captures on both pin edges.
// - Channel 0 third register, top bits 11, captures on channel 1 counts.
// - Channel 1 first register, top bits 11, captures on channel 0 events.
// - Pin stays low after reset or standby until the field is written.
// - Buffer enable on channel 0 disables the third register's events.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`include "tpio_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tpio_top (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Power state
  input wire logic STANDBY,
  // Timer side, channel 0 third register
  input wire logic CH0_THIRD_MATCH,
  input wire logic CH1_COUNT_STEP,
  output logic CH0_THIRD_CAPTURE,
  output logic CH0_THIRD_CMP_EN,
  // Timer side, channel 1 first register
  input wire logic CH1_FIRST_MATCH,
  input wire logic CH0_FIRST_EVENT,
  output logic CH1_FIRST_CAPTURE,
  output logic CH1_FIRST_CMP_EN,
  // Pins
  input wire logic CH0_PIN_THIRD_I,
  output logic CH0_PIN_THIRD_O,
  output logic CH0_PIN_THIRD_OE,
  input wire logic CH1_PIN_FIRST_I,
  output logic CH1_PIN_FIRST_O,
  output logic CH1_PIN_FIRST_OE
);
  import tpio_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  logic rst_a_reg;
  logic rst_n_reg;
  logic [2:0] p0_sync_reg;
  logic [2:0] p1_sync_reg;
  logic p0_reg;
  logic p1_reg;
  logic [7:0] ch0_low_pin_io_control_reg;
  logic [7:0] ch1_pin_io_control_reg;
  logic first_pair_buffer_enable_reg;
  logic wr0;
  logic wr1;
  logic acc;
  logic hit;
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;
  tpio_chan_in_t c0_in;
  tpio_chan_in_t c1_in;
  tpio_chan_out_t c0_out;
  tpio_chan_out_t c1_out;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_a_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_n_reg <= rst_a_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge MCLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      p0_sync_reg <= 3'b000;
      p1_sync_reg <= 3'b000;
    end else begin
      p0_sync_reg <= {p0_sync_reg[1:0], CH0_PIN_THIRD_I};
      p1_sync_reg <= {p1_sync_reg[1:0], CH1_PIN_FIRST_I};
    end
  end

  // Accept a level once stages 1 and 2 agree, filtering a late flip
  always_ff @(posedge MCLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      p0_reg <= 1'b0;
      p1_reg <= 1'b0;
    end else begin
      if (p0_sync_reg[2] == p0_sync_reg[1])
        p0_reg <= p0_sync_reg[2];
      if (p1_sync_reg[2] == p1_sync_reg[1])
        p1_reg <= p1_sync_reg[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB decode; writes land in the access phase only
  assign acc = PSEL && PENABLE;
  assign wr0 = acc && PWRITE && PADDR == `TPIO_OFS_CH0_LOW_IO;
  assign wr1 = acc && PWRITE && PADDR == `TPIO_OFS_CH1_IO;

  // Control registers
  always_ff @(posedge MCLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ch0_low_pin_io_control_reg <= `TPIO_IO_RESET;
      ch1_pin_io_control_reg <= `TPIO_IO_RESET;
      first_pair_buffer_enable_reg <= 1'b0;
    end else begin
      if (wr0)
        ch0_low_pin_io_control_reg <= PWDATA[7:0];
      if (wr1)
        ch1_pin_io_control_reg <= PWDATA[7:0];
      if (acc && PWRITE && PADDR == `TPIO_OFS_CH0_MODE)
        first_pair_buffer_enable_reg <= PWDATA[`TPIO_BUF_BIT];
    end
  end

  // Read mux; unmapped addresses answer with an error
  always_comb begin
    rdata_next = 32'h0000_0000;
    hit = 1'b1;
    if (PADDR == `TPIO_OFS_CH0_LOW_IO)
      rdata_next[7:0] = ch0_low_pin_io_control_reg;
    else if (PADDR == `TPIO_OFS_CH1_IO)
      rdata_next[7:0] = ch1_pin_io_control_reg;
    else if (PADDR == `TPIO_OFS_CH0_MODE)
      rdata_next[0] = first_pair_buffer_enable_reg;
    else if (PADDR == `TPIO_OFS_STATUS)
      rdata_next[3:0] = {c1_out.pin_out, c1_out.pin_oe,
                         c0_out.pin_out, c0_out.pin_oe};
    else
      hit = 1'b0;
  end

  // Read data held in a flop, loaded during the setup cycle
  always_ff @(posedge MCLK or negedge rst_n_reg) begin
    if (!rst_n_reg)
      rdata_reg <= 32'h0000_0000;
    else if (PSEL && !PENABLE && !PWRITE)
      rdata_reg <= rdata_next;
  end

  assign PRDATA = rdata_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = acc && !hit;

  ////////////////////////////////////////////////////////////////////////
  // Channel 0 third register; cross trigger from channel 1 counts
  assign c0_in.cmp_match = CH0_THIRD_MATCH;
  assign c0_in.pin_in = p0_reg;
  assign c0_in.trig_evt = CH1_COUNT_STEP;
  // cross trigger from channel 0 first register events
  assign c1_in.cmp_match = CH1_FIRST_MATCH;
  assign c1_in.pin_in = p1_reg;
  assign c1_in.trig_evt = CH0_FIRST_EVENT;

  // buffer use inhibits the third register
  tpio_chan u_ch0 (
    .clk(MCLK),
    .rst_n(rst_n_reg),
    .code(ch0_low_pin_io_control_reg[`TPIO_FLD_HI:`TPIO_FLD_LO]),
    .code_wr(wr0),
    .inhibit(first_pair_buffer_enable_reg),
    .standby(STANDBY),
    .cin(c0_in),
    .cout(c0_out)
  );

  tpio_chan u_ch1 (
    .clk(MCLK),
    .rst_n(rst_n_reg),
    .code(ch1_pin_io_control_reg[`TPIO_FLD_HI:`TPIO_FLD_LO]),
    .code_wr(wr1),
    .inhibit(1'b0),
    .standby(STANDBY),
    .cin(c1_in),
    .cout(c1_out)
  );

  assign CH0_PIN_THIRD_O = c0_out.pin_out;
  assign CH0_PIN_THIRD_OE = c0_out.pin_oe;
  assign CH0_THIRD_CAPTURE = c0_out.cap_strobe;
  assign CH0_THIRD_CMP_EN = c0_out.cmp_en;
  assign CH1_PIN_FIRST_O = c1_out.pin_out;
  assign CH1_PIN_FIRST_OE = c1_out.pin_oe;
  assign CH1_FIRST_CAPTURE = c1_out.cap_strobe;
  assign CH1_FIRST_CMP_EN = c1_out.cmp_en;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!rst_n_reg);

  // Channel 1 free to follow a match: no pending write, no low hold;
  // the pin update lags a write by one edge, so matches then lose
  logic ch1_free;
  assign ch1_free = !wr1 && !STANDBY && !u_ch1.wr_seen_reg
                    && !u_ch1.low_hold_reg;

  cmp_low_a: assert property (
    (ch1_pin_io_control_reg[3:0] == 4'b0001 || ch1_pin_io_control_reg[3:0]
     == 4'b0101) && CH1_FIRST_MATCH && ch1_free
    |=> !CH1_PIN_FIRST_O) else $error("pin not low after match");
  cmp_high_a: assert property (
    ch1_pin_io_control_reg[3:0] == 4'b0010 && CH1_FIRST_MATCH && ch1_free
    |=> CH1_PIN_FIRST_O) else $error("pin not high after match");
  cmp_toggle_a: assert property (
    ch1_pin_io_control_reg[3:0] == 4'b0011 && CH1_FIRST_MATCH && ch1_free
    |=> CH1_PIN_FIRST_O != $past(CH1_PIN_FIRST_O))
    else $error("pin did not toggle");
  cap_rise_a: assert property (
    ch1_pin_io_control_reg[3:0] == 4'b1000 && p1_reg && !$past(p1_reg)
    && !STANDBY |=> CH1_FIRST_CAPTURE) else $error("rising capture missed");
  cap_fall_a: assert property (
    ch1_pin_io_control_reg[3:0] == 4'b1001 && p1_reg && !$past(p1_reg)
    |=> !CH1_FIRST_CAPTURE) else $error("capture on wrong edge");
  cap_both_a: assert property (
    ch1_pin_io_control_reg[3:1] == 3'b101 && p1_reg != $past(p1_reg)
    && !STANDBY |=> CH1_FIRST_CAPTURE) else $error("edge capture missed");
  cross_trig_a: assert property (
    ch1_pin_io_control_reg[3:2] == 2'b11 && CH0_FIRST_EVENT && !STANDBY
    |=> CH1_FIRST_CAPTURE) else $error("cross capture missed");
  buf_inhibit_a: assert property (
    first_pair_buffer_enable_reg
    |-> !CH0_THIRD_CMP_EN ##1 !CH0_THIRD_CAPTURE)
    else $error("event while buffered");
  init_level_a: assert property (
    wr1 && !PWDATA[3] && PWDATA[1:0] != 2'b00 ##1 !STANDBY
    |=> CH1_PIN_FIRST_O == $past(PWDATA[2], 2))
    else $error("bad initial level");
  hold_pin_a: assert property (
    ch1_pin_io_control_reg[3:0] == 4'b0000 && !wr1 && !STANDBY
    |=> $stable(CH1_PIN_FIRST_O)) else $error("pin moved on hold");
  standby_low_a: assert property (
    STANDBY |=> !CH0_PIN_THIRD_O && !CH1_PIN_FIRST_O)
    else $error("pin not low in standby");
  count_trig_a: assert property (
    ch0_low_pin_io_control_reg[3:2] == 2'b11 && CH1_COUNT_STEP && !STANDBY
    && !first_pair_buffer_enable_reg |=> CH0_THIRD_CAPTURE)
    else $error("count capture missed");
  cap_fall_hit_a: assert property (
    ch1_pin_io_control_reg[3:0] == 4'b1001 && !p1_reg && $past(p1_reg)
    && !STANDBY |=> CH1_FIRST_CAPTURE) else $error("falling capture missed");
  hold_low_a: assert property (
    u_ch1.low_hold_reg && !u_ch1.wr_seen_reg |=> !CH1_PIN_FIRST_O)
    else $error("pin left low hold");
  cap_role_oe_a: assert property (
    ch1_pin_io_control_reg[3] |-> !CH1_PIN_FIRST_OE)
    else $error("pin driven in capture role");
  cmp_role_a: assert property (
    !ch1_pin_io_control_reg[3] && ch1_pin_io_control_reg[1:0] != 2'b00
    |-> CH1_FIRST_CMP_EN && CH1_PIN_FIRST_OE)
    else $error("compare role not enabled");
  buf_pin_a: assert property (
    first_pair_buffer_enable_reg && !STANDBY |=> $stable(CH0_PIN_THIRD_O))
    else $error("pin moved while buffered");

  write_cov: cover property (wr0 ##1 wr1);
  cap_cov: cover property (CH1_FIRST_CAPTURE);
  toggle_cov: cover property (CH0_PIN_THIRD_O ##1 !CH0_PIN_THIRD_O);
  err_cov: cover property (PSLVERR);
  hold_cov: cover property (u_ch1.low_hold_reg && CH1_FIRST_MATCH);
endmodule
`default_nettype wire

// File: tpio_top_bench.sv
// Purpose: Register-driven checks of pin roles for both channels
// Assumes: Zero-wait APB slave, capture within ten cycles of a cause
// Notes: Pins are sampled at the falling edge, capture pulses are counted at the rising edge
`timescale 1ns/1ps
`default_nettype none
module tpio_top_bench;
  logic MCLK = 1'b0;
  logic RESET_N = 1'b0;
  logic PSEL, PENABLE, PWRITE, STANDBY;
  logic [11:0] PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA, rd;
  logic PREADY, PSLVERR, err, e;
  logic m0, m1, stp, ev, p0, p1, o0, oe0, o1, oe1, cap0, cap1, ce0, ce1;
  int failures = 0;
  int num_checks = 0;
  int n0 = 0, n1 = 0, b0 = 0, b1 = 0;
  always #2.5 MCLK = ~MCLK;
  // Count capture pulses; they stand one cycle only
  always @(posedge MCLK) begin
    if (cap0 === 1'b1) n0 <= n0 + 1;
    if (cap1 === 1'b1) n1 <= n1 + 1;
  end
  tpio_top dut (.MCLK(MCLK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .STANDBY(STANDBY),
    .CH0_THIRD_MATCH(m0), .CH1_COUNT_STEP(stp), .CH0_THIRD_CAPTURE(cap0),
    .CH0_THIRD_CMP_EN(ce0), .CH1_FIRST_MATCH(m1), .CH0_FIRST_EVENT(ev),
    .CH1_FIRST_CAPTURE(cap1), .CH1_FIRST_CMP_EN(ce1),
    .CH0_PIN_THIRD_I(p0), .CH0_PIN_THIRD_O(o0), .CH0_PIN_THIRD_OE(oe0),
    .CH1_PIN_FIRST_I(p1), .CH1_PIN_FIRST_O(o1), .CH1_PIN_FIRST_OE(oe1));
  tpio_timer_model m (.clk(MCLK), .o0(o0), .oe0(oe0), .o1(o1),
    .oe1(oe1), .pin0(p0), .pin1(p1), .match0(m0), .match1(m1),
    .step(stp), .event0(ev));
  //////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (failures == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; held until pready is seen high
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    @(posedge MCLK);
    while (PREADY !== 1'b1 && n < 16) begin
      @(posedge MCLK);
      n++;
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // Idle edge, so the next setup never reassigns PSEL in this step
    @(posedge MCLK);
    if (n == 16) begin
      failures++;
      test_done();
    end
  endtask
  // Write both fields, then let one edge pass
  task automatic both(input int c);
    xfer(1'b1, 12'h000, 32'(c));
    xfer(1'b1, 12'h004, 32'(c));
    @(posedge MCLK);
  endtask
  task automatic pins(input logic [1:0] exp);
    @(negedge MCLK);
    check("pins", {o1, o0}, exp);
    @(posedge MCLK);
  endtask
  // Let stale edges pass, then take a baseline of capture counts
  task automatic snap;
    repeat (10) @(posedge MCLK);
    b0 = n0;
    b1 = n1;
  endtask
  task automatic caps(input int e0, e1);
    repeat (10) @(posedge MCLK);
    check("capture ch0", 32'(n0 - b0), 32'(e0));
    check("capture ch1", 32'(n1 - b1), 32'(e1));
  endtask
  initial begin
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    PWRITE <= 1'b0;
    STANDBY <= 1'b0;
    PADDR <= 12'h000;
    PWDATA <= 32'h0000_0000;
    repeat (8) @(posedge MCLK);
    RESET_N <= 1'b1;
    repeat (4) @(posedge MCLK);
    pins(2'b00);
    xfer(1'b0, 12'h004, 32'h0000_0000);
    check("ch1 io reset", rd, 32'h0000_0000);
    xfer(1'b1, 12'h000, 32'h0000_00F0);
    xfer(1'b0, 12'h000, 32'h0000_0000);
    check("ch0 io rw", {err, rd[7:0]}, 32'h0000_00F0);
    for (int c = 1; c < 8; c++) begin
      if (c != 4) begin
        both(c);
        pins({c[2], c[2]});
        check("oe cmp", {oe1, oe0, ce1, ce0}, 32'h0000_000F);
        m.pulse(4'h3);
        e = (c[1:0] == 2'b01) ? 1'b0 : (c[1:0] == 2'b10) ? 1'b1 : ~c[2];
        @(posedge MCLK);
        pins({e, e});
      end
    end
    both(6);
    xfer(1'b1, 12'h000, 32'h0000_0000);
    xfer(1'b1, 12'h004, 32'h0000_0004);
    m.pulse(4'h3);
    @(posedge MCLK);
    pins(2'b11);
    for (int c = 8; c < 11; c++) begin
      both(c);
      check("oe cap", {oe1, oe0}, 32'h0000_0000);
      snap();
      m.set_pins(1'b1);
      caps(c != 9, c != 9);
      snap();
      m.set_pins(1'b0);
      caps(c != 8, c != 8);
    end
    both(12);
    snap();
    m.pulse(4'hC);
    caps(1, 1);
    xfer(1'b1, 12'h008, 32'h0000_0001);
    snap();
    m.pulse(4'hC);
    caps(0, 1);
    xfer(1'b1, 12'h008, 32'h0000_0000);
    // standby forces pins low until rewritten
    both(6);
    STANDBY <= 1'b1;
    repeat (3) @(posedge MCLK);
    pins(2'b00);
    STANDBY <= 1'b0;
    repeat (3) @(posedge MCLK);
    pins(2'b00);
    m.pulse(4'h3);
    pins(2'b00);
    both(6);
    pins(2'b11);
    xfer(1'b0, 12'h00C, 32'h0000_0000);
    check("status", rd, 32'h0000_000F);
    xfer(1'b0, 12'h010, 32'h0000_0000);
    check("unmapped err", 32'(err), 32'h0000_0001);
    check("unmapped data", rd, 32'h0000_0000);
    test_done();
  end
endmodule
`default_nettype wire
